// [src/rsf_pkg.sv]
package rsf_pkg;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
    localparam int CHAR_BITS = 11;
    // silent intervals counted in half bit times
    localparam int T15_HALF = 3 * CHAR_BITS;
    localparam int T35_HALF = 7 * CHAR_BITS;
    localparam int DIV_W = 17;
    localparam int BAUD_RATE [8] = '{2400, 4800, 9600, 19200, 38400, 57600, 76800, 115200};

    // ==========================================================
    // configuration codes and reset values
    localparam logic [1:0] FMT_EVEN = 2'h0;
    localparam logic [1:0] FMT_ODD = 2'h1;
    localparam logic [1:0] FMT_NONE = 2'h2;
    localparam logic [1:0] FMT_RESET = FMT_EVEN;
    localparam logic [7:0] ADDR_BCAST = 8'h00;
    localparam logic [7:0] ADDR_MAX = 8'hF7;
    localparam logic [7:0] ADDR_RESET = 8'h01;
    localparam logic [2:0] BAUD_RESET = 3'h2;

    // ==========================================================
    // frame fields
    localparam logic [7:0] FUNC_NONE = 8'h00;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] CRC_GOOD = 16'h0000;
    localparam logic [3:0] MIN_FRAME = 4'h4;

    // half bit period in clocks, rounded down
    function automatic int half_div(input int clk_hz, input logic [2:0] sel);
        return clk_hz / (2 * BAUD_RATE[sel]);
    endfunction

    // reflected crc over one byte
    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

endpackage

// [src/rsf_tick.sv]
`timescale 1ns/100ps
module rsf_tick #(
    parameter int W = 17
) (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // async reset
    input wire logic ce_i, // clock enable
    input wire logic restart_i, // realign phase
    input wire logic [W-1:0] div_i, // clocks per tick
    output logic tick_o // one cycle tick
);
    logic [W-1:0] cnt;

    if (W < 2) begin : g_chk
        $error("rsf_tick width too small");
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= '0;
        end else if (ce_i) begin
            if (restart_i || cnt == '0) begin
                cnt <= div_i - W'(1);
            end else begin
                cnt <= cnt - W'(1);
            end
        end
    end

    assign tick_o = ce_i && !restart_i && cnt == '0;
endmodule // rsf_tick

// [src/rsf_framer.sv]
`timescale 1ns/100ps
// Functional notes
// - character: start bit, eight data bits LSB first, parity option, stop bits
// - parity mode adds parity plus one stop; no parity uses two stops
// - format resets to even parity with one stop bit
// - rate selectable 2400 to 115200 baud; all gap timing follows it
// - own address accepted only within 1 to 247; zero never
// - frames to address zero or own address are accepted
// - broadcast frames never get a reply
// - a frame starts after 3.5 character times of idle, or after a gap above 1.5 characters within a frame
// - 3.5 idle character times end a frame
// - gap above 1.5 characters flushes partial frame, flags error, restarts
// - bytes within 1.5 characters append to previous frame
// - frame order: address, function, data, sixteen bit check
// - receiver watches line always and decodes first byte
// - replies carry own configured address
// - function byte eight bits; zero is not a valid code
// - normal reply echoes function byte unchanged
// - exception reply sets function bit 7 and carries cause code
// - bad addressed request gets exception reply or silence
// - transmit only in reply to individually addressed query
// - check field sent low byte first, high byte last
// - receiver recomputes check; mismatch discards frame silently
module rsf_framer #(
    parameter int CLK_HZ = rsf_pkg::CLK_HZ
) (
    input wire logic CLK_I, // system clock
    input wire logic RESET_I, // async reset, high
    input wire logic CE_I, // clock enable
    input wire logic RXD_I, // serial line in
    output logic TXD_O, // serial line out
    output logic TX_EN_O, // line driver enable
    input wire logic CFG_WE_I, // load configuration
    input wire logic [7:0] CFG_ADDR_I, // own address
    input wire logic [2:0] CFG_BAUD_I, // rate select
    input wire logic [1:0] CFG_FMT_I, // character format
    output logic [7:0] ADDR_O, // active address
    output logic [2:0] BAUD_O, // active rate select
    output logic [1:0] FMT_O, // active format
    output logic [7:0] RX_DATA_O, // received byte
    output logic RX_VALID_O, // byte strobe
    output logic FRAME_OK_O, // good frame end
    output logic FRAME_BCAST_O, // good frame was broadcast
    output logic FRAME_ERR_O, // discarded frame
    output logic [7:0] FUNC_O, // received function
    output logic REPLY_PENDING_O, // reply may be sent
    input wire logic REPLY_START_I, // start reply
    input wire logic REPLY_EXC_I, // reply is exception
    input wire logic REPLY_DROP_I, // stay silent
    input wire logic [7:0] TX_DATA_I, // reply data byte
    input wire logic TX_VALID_I, // data byte valid
    input wire logic TX_LAST_I, // last data byte
    output logic TX_READY_O // data byte taken
);
    localparam int DW = rsf_pkg::DIV_W;

    if (CLK_HZ / 4800 >= 2 ** DW || CLK_HZ / 230400 < 2) begin : g_chk
        $error("CLK_HZ outside divider range");
    end

    typedef enum logic [0:0] {R_IDLE, R_BITS} rsf_rx_t;
    typedef enum logic [2:0] {T_IDLE, T_ADDR, T_FUNC, T_DATA, T_CRCL, T_CRCH, T_DRAIN} rsf_tx_t;

    logic [DW-1:0] div;
    logic rx_meta, rx_s2, rx_s3, rxd, rxd_q;
    rsf_rx_t rx_state;
    logic [4:0] hcnt;
    logic [7:0] rx_sh;
    logic rx_bad_char, char_done, char_err;
    logic [6:0] gap;
    logic rx_tick, rx_fall;
    logic in_frame, match, bcast, bad;
    logic [3:0] count;
    logic [15:0] rx_crc;
    logic new_frame, flush, frame_end, frame_good;
    rsf_tx_t tx_state;
    logic [7:0] exc_func;
    logic [15:0] tx_crc;
    logic ser_busy, ser_load, tx_tick, half;
    logic [10:0] sh;
    logic [3:0] bits_left;
    logic [7:0] tx_byte;

    // ==========================================================
    // configuration
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            ADDR_O <= rsf_pkg::ADDR_RESET;
            BAUD_O <= rsf_pkg::BAUD_RESET;
            FMT_O <= rsf_pkg::FMT_RESET;
        end else if (CE_I && CFG_WE_I) begin
            if (CFG_ADDR_I != rsf_pkg::ADDR_BCAST && CFG_ADDR_I <= rsf_pkg::ADDR_MAX) begin
                ADDR_O <= CFG_ADDR_I;
            end
            if (CFG_FMT_I <= rsf_pkg::FMT_NONE) begin
                FMT_O <= CFG_FMT_I;
            end
            BAUD_O <= CFG_BAUD_I;
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            div <= DW'(rsf_pkg::half_div(CLK_HZ, rsf_pkg::BAUD_RESET));
        end else if (CE_I) begin
            div <= DW'(rsf_pkg::half_div(CLK_HZ, BAUD_O));
        end
    end

    // ==========================================================
    // line input synchroniser
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            rx_meta <= 1'b1;
            rx_s2 <= 1'b1;
            rx_s3 <= 1'b1;
            rxd <= 1'b1;
            rxd_q <= 1'b1;
        end else if (CE_I) begin
            rx_meta <= RXD_I;
            rx_s2 <= rx_meta;
            rx_s3 <= rx_s2;
            rxd <= (rx_s2 == rx_s3) ? rx_s3 : rxd;
            rxd_q <= rxd;
        end
    end

    assign rx_fall = rx_state == R_IDLE && rxd_q && !rxd;

    rsf_tick #(.W(DW)) u_rx_tick (
        .clk_i(CLK_I),
        .rst_i(RESET_I),
        .ce_i(CE_I),
        .restart_i(rx_fall),
        .div_i(div),
        .tick_o(rx_tick)
    );

    // ==========================================================
    // character receiver, sampled at mid bit
    assign char_done = rx_state == R_BITS && rx_tick && hcnt == 5'(2 * rsf_pkg::CHAR_BITS - 2);
    assign char_err = rx_bad_char || !rxd;

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            rx_state <= R_IDLE;
            hcnt <= '0;
            rx_sh <= '0;
            rx_bad_char <= 1'b0;
        end else if (CE_I) begin
            unique case (rx_state)
                R_IDLE: begin
                    if (rx_fall) begin
                        rx_state <= R_BITS;
                        hcnt <= '0;
                        rx_bad_char <= 1'b0;
                    end
                end
                R_BITS: begin
                    if (rx_tick) begin
                        hcnt <= hcnt + 5'h01;
                        if (hcnt == 5'h00 && rxd) begin
                            rx_state <= R_IDLE; // false start
                        end else if (hcnt >= 5'h02 && hcnt <= 5'h10 && !hcnt[0]) begin
                            rx_sh <= {rxd, rx_sh[7:1]};
                        end else if (hcnt == 5'h12) begin
                            if (rsf_pkg::FMT_NONE == FMT_O) begin
                                rx_bad_char <= !rxd;
                            end else begin
                                rx_bad_char <= rxd != (^rx_sh ^ (FMT_O == rsf_pkg::FMT_ODD));
                            end
                        end
                        if (char_done) begin
                            rx_state <= R_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // silent interval timing and frame assembly
    assign new_frame = char_done && (gap >= 7'(rsf_pkg::T35_HALF)
                       || (in_frame && gap > 7'(rsf_pkg::T15_HALF)));
    assign flush = char_done && in_frame && gap > 7'(rsf_pkg::T15_HALF)
                   && gap < 7'(rsf_pkg::T35_HALF);
    assign frame_end = in_frame && rx_state == R_IDLE && rx_tick
                       && gap == 7'(rsf_pkg::T35_HALF - 1);
    assign frame_good = !bad && rx_crc == rsf_pkg::CRC_GOOD && count >= rsf_pkg::MIN_FRAME
                        && FUNC_O != rsf_pkg::FUNC_NONE;

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            gap <= 7'(rsf_pkg::T35_HALF);
        end else if (CE_I) begin
            if (char_done) begin
                gap <= '0;
            end else if (rx_state == R_IDLE && rx_tick && gap < 7'(rsf_pkg::T35_HALF)) begin
                gap <= gap + 7'h01;
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            in_frame <= 1'b0;
            match <= 1'b0;
            bcast <= 1'b0;
            bad <= 1'b0;
            count <= '0;
            rx_crc <= rsf_pkg::CRC_INIT;
            FUNC_O <= rsf_pkg::FUNC_NONE;
        end else if (CE_I) begin
            if (new_frame) begin
                in_frame <= 1'b1;
                match <= rx_sh == ADDR_O || rx_sh == rsf_pkg::ADDR_BCAST;
                bcast <= rx_sh == rsf_pkg::ADDR_BCAST;
                bad <= char_err;
                count <= 4'h1;
                rx_crc <= rsf_pkg::crc_step(rsf_pkg::CRC_INIT, rx_sh);
            end else if (char_done && in_frame) begin
                bad <= bad || char_err;
                count <= (count == 4'hF) ? count : count + 4'h1;
                rx_crc <= rsf_pkg::crc_step(rx_crc, rx_sh);
                if (count == 4'h1) begin
                    FUNC_O <= rx_sh;
                end
            end else if (frame_end) begin
                in_frame <= 1'b0;
            end
        end
    end

    // ==========================================================
    // user side strobes
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            RX_DATA_O <= '0;
            RX_VALID_O <= 1'b0;
            FRAME_OK_O <= 1'b0;
            FRAME_BCAST_O <= 1'b0;
            FRAME_ERR_O <= 1'b0;
        end else if (CE_I) begin
            RX_VALID_O <= char_done && in_frame && !new_frame && match;
            if (char_done) begin
                RX_DATA_O <= rx_sh;
            end
            FRAME_OK_O <= frame_end && match && frame_good;
            FRAME_BCAST_O <= frame_end && match && frame_good && bcast;
            FRAME_ERR_O <= (flush || frame_end) && match && !(frame_end && frame_good);
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            REPLY_PENDING_O <= 1'b0;
        end else if (CE_I) begin
            if (frame_end && match && frame_good && !bcast) begin
                REPLY_PENDING_O <= 1'b1;
            end else if (REPLY_START_I || REPLY_DROP_I || new_frame || bcast) begin
                REPLY_PENDING_O <= 1'b0;
            end
        end
    end

    // ==========================================================
    // reply sequencer
    assign ser_load = !ser_busy && (tx_state == T_ADDR || tx_state == T_FUNC || tx_state == T_CRCL
                      || tx_state == T_CRCH || (tx_state == T_DATA && TX_VALID_I));
    assign TX_READY_O = !ser_busy && tx_state == T_DATA;
    assign TX_EN_O = tx_state != T_IDLE;

    always_comb begin
        unique case (tx_state)
            T_ADDR: tx_byte = ADDR_O;
            T_FUNC: tx_byte = exc_func;
            T_CRCL: tx_byte = tx_crc[7:0];
            T_CRCH: tx_byte = tx_crc[15:8];
            default: tx_byte = TX_DATA_I;
        endcase
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            tx_state <= T_IDLE;
            exc_func <= rsf_pkg::FUNC_NONE;
            tx_crc <= rsf_pkg::CRC_INIT;
        end else if (CE_I) begin
            unique case (tx_state)
                T_IDLE: begin
                    if (REPLY_PENDING_O && REPLY_START_I && !REPLY_DROP_I) begin
                        tx_state <= T_ADDR;
                        tx_crc <= rsf_pkg::CRC_INIT;
                        exc_func <= REPLY_EXC_I ? (FUNC_O | rsf_pkg::EXC_FLAG) : FUNC_O;
                    end
                end
                T_DRAIN: begin
                    if (!ser_busy) begin
                        tx_state <= T_IDLE;
                    end
                end
                default: begin
                    if (ser_load) begin
                        if (tx_state != T_CRCL && tx_state != T_CRCH) begin
                            tx_crc <= rsf_pkg::crc_step(tx_crc, tx_byte);
                        end
                        unique case (tx_state)
                            T_ADDR: tx_state <= T_FUNC;
                            T_FUNC: tx_state <= T_DATA;
                            T_DATA: tx_state <= TX_LAST_I ? T_CRCL : T_DATA;
                            T_CRCL: tx_state <= T_CRCH;
                            default: tx_state <= T_DRAIN;
                        endcase
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // character transmitter
    rsf_tick #(.W(DW)) u_tx_tick (
        .clk_i(CLK_I),
        .rst_i(RESET_I),
        .ce_i(CE_I),
        .restart_i(ser_load),
        .div_i(div),
        .tick_o(tx_tick)
    );

    assign ser_busy = bits_left != 4'h0;
    assign TXD_O = sh[0];

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            sh <= '1;
            bits_left <= '0;
            half <= 1'b0;
        end else if (CE_I) begin
            if (ser_load) begin
                sh <= {1'b1, (FMT_O == rsf_pkg::FMT_NONE) ? 1'b1
                       : (^tx_byte ^ (FMT_O == rsf_pkg::FMT_ODD)), tx_byte, 1'b0};
                bits_left <= 4'(rsf_pkg::CHAR_BITS);
                half <= 1'b0;
            end else if (ser_busy && tx_tick) begin
                half <= !half;
                if (half) begin
                    sh <= {1'b1, sh[10:1]};
                    bits_left <= bits_left - 4'h1;
                end
            end
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);

    AST_ADDR_RANGE: assert property (ADDR_O != 8'h00 && ADDR_O <= 8'hF7)
        else $error("own address out of range");
    AST_FMT_RESET: assert property ($past(RESET_I) |-> FMT_O == rsf_pkg::FMT_EVEN)
        else $error("format not even after reset");
    AST_BCAST_SILENT: assert property (CE_I && frame_end && bcast |=> !REPLY_PENDING_O)
        else $error("reply armed after broadcast");
    AST_TX_ONLY_REPLY: assert property ($rose(TX_EN_O) |-> $past(REPLY_PENDING_O))
        else $error("transmit without pending reply");
    AST_TX_ADDR: assert property (CE_I && ser_load && tx_state == T_ADDR |=> sh[8:1] == ADDR_O)
        else $error("reply address not own address");
    AST_FUNC_ECHO: assert property (ser_load && tx_state == T_FUNC
        |-> tx_byte[6:0] == FUNC_O[6:0] && (tx_byte[7] || !FUNC_O[7]))
        else $error("reply function byte wrong");
    AST_GAP_FLUSH: assert property (CE_I && flush && match |=> FRAME_ERR_O && count == 4'h1)
        else $error("partial frame not flushed");
    AST_CRC_BAD: assert property (CE_I && frame_end && rx_crc != 16'h0000 |=> !FRAME_OK_O)
        else $error("bad check accepted");
    AST_NEW_ADDR: assert property (CE_I && char_done && gap >= 7'(rsf_pkg::T35_HALF)
        |=> count == 4'h1)
        else $error("frame not restarted after long gap");
    AST_CHAR_LEN: assert property (CE_I && ser_load
        |=> bits_left == 4'(rsf_pkg::CHAR_BITS) ##1 TXD_O == 1'b0)
        else $error("character not eleven bits");
endmodule // rsf_framer

// [dv/rsf_master.sv]
`timescale 1ns/100ps
module rsf_master (
    input wire logic clk_i, // system clock
    input wire logic txd_i, // slave line out
    input wire logic tx_en_i, // slave driver on
    output logic rxd_o // line to slave
);
    int bit_clks = 4;
    logic [1:0] fmt = 2'h0;
    logic [7:0] got [$];
    int bad = 0;

    // biased bus idles high
    initial rxd_o = 1'b1;

    // ==========================================================
    // query side, changed on falling edges
    task automatic send_byte(input logic [7:0] b, input bit flip);
        logic [10:0] ch;
        ch = {1'b1, ^b ^ (fmt == rsf_pkg::FMT_ODD) ^ flip, b, 1'b0};
        if (fmt == rsf_pkg::FMT_NONE) ch[9] = 1'b1;
        for (int i = 0; i < 11; i++) begin
            rxd_o = ch[i];
            repeat (bit_clks) @(negedge clk_i);
        end
    endtask

    // ==========================================================
    // reply side, sampled mid-bit
    always begin : rx
        logic [10:0] ch;
        logic par;
        @(negedge txd_i iff tx_en_i === 1'b1);
        repeat (bit_clks / 2) @(negedge clk_i);
        for (int i = 0; i < 11; i++) begin
            ch[i] = txd_i;
            if (i < 10) repeat (bit_clks) @(negedge clk_i);
        end
        par = (fmt == rsf_pkg::FMT_NONE) ? 1'b1 : ^ch[8:1] ^ (fmt == rsf_pkg::FMT_ODD);
        if (ch[0] !== 1'b0 || ch[10] !== 1'b1 || ch[9] !== par) bad++;
        got.push_back(ch[8:1]);
    end
endmodule // rsf_master

// [dv/testbench.sv]
`timescale 1ns/100ps
module testbench;
    typedef logic [7:0] rsf_bytes_t [$];
    localparam int CLK_HZ = 460800;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rxd, txd, tx_en, tx_ready, rx_valid, frame_ok, frame_bc, frame_err, pend;
    logic [7:0] addr_o, rx_data, func_o;
    logic [2:0] baud_o;
    logic [1:0] fmt_o;
    logic we = 1'b0;
    logic [7:0] c_addr = 8'h00;
    logic [2:0] c_baud = 3'h0;
    logic [1:0] c_fmt = 2'h0;
    logic r_start = 1'b0;
    logic r_exc = 1'b0;
    logic r_drop = 1'b0;
    logic [7:0] t_data = 8'h00;
    logic t_valid = 1'b0;
    logic t_last = 1'b0;
    logic [7:0] own = rsf_pkg::ADDR_RESET;
    logic [1:0] fm = rsf_pkg::FMT_RESET;
    logic [7:0] fn;
    rsf_bytes_t rx_q, f;
    int n_errors = 0;
    int tests_run = 0;
    int n_ok = 0, n_err = 0, n_bc = 0;
    int seed;

    rsf_framer #(.CLK_HZ(CLK_HZ)) uut (
        .CLK_I(clk), .RESET_I(rst), .CE_I(1'b1), .RXD_I(rxd), .TXD_O(txd), .TX_EN_O(tx_en),
        .CFG_WE_I(we), .CFG_ADDR_I(c_addr), .CFG_BAUD_I(c_baud), .CFG_FMT_I(c_fmt),
        .ADDR_O(addr_o), .BAUD_O(baud_o), .FMT_O(fmt_o), .RX_DATA_O(rx_data),
        .RX_VALID_O(rx_valid), .FRAME_OK_O(frame_ok), .FRAME_BCAST_O(frame_bc),
        .FRAME_ERR_O(frame_err), .FUNC_O(func_o), .REPLY_PENDING_O(pend),
        .REPLY_START_I(r_start), .REPLY_EXC_I(r_exc), .REPLY_DROP_I(r_drop), .TX_DATA_I(t_data),
        .TX_VALID_I(t_valid), .TX_LAST_I(t_last), .TX_READY_O(tx_ready));
    rsf_master m (.clk_i(clk), .txd_i(txd), .tx_en_i(tx_en), .rxd_o(rxd));

    always #2.5 clk = ~clk;

    // ==========================================================
    // pulse monitor
    always @(negedge clk) begin
        if (rx_valid === 1'b1) rx_q.push_back(rx_data);
        if (frame_ok === 1'b1) n_ok++;
        if (frame_err === 1'b1) n_err++;
        if (frame_bc === 1'b1) n_bc++;
    end

    // ==========================================================
    // helpers
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic rsf_bytes_t with_crc(input rsf_bytes_t q);
        logic [15:0] c;
        c = rsf_pkg::CRC_INIT;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ rsf_pkg::CRC_POLY) : (c >> 1);
        end
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        return q;
    endfunction

    task automatic cfg(input logic [7:0] a, input logic [2:0] b, input logic [1:0] x);
        c_addr = a;
        c_baud = b;
        c_fmt = x;
        we = 1'b1;
        @(negedge clk);
        we = 1'b0;
        if (a != 8'h00 && a <= 8'hF7) own = a;
        if (x != 2'h3) fm = x;
        @(negedge clk);
        check({addr_o, baud_o, fmt_o}, {own, b, fm});
        m.bit_clks = 2 * (CLK_HZ / (2 * rsf_pkg::BAUD_RATE[b]));
        m.fmt = fm;
    endtask

    // pe: byte with flipped parity, gp: byte preceded by a two character gap
    task automatic send(input rsf_bytes_t q, input int pe, input int gp, input bit idle);
        foreach (q[i]) begin
            if (i == gp) repeat (22 * m.bit_clks) @(negedge clk);
            m.send_byte(q[i], i == pe);
        end
        if (idle) repeat (55 * m.bit_clks) @(negedge clk);
    endtask

    task automatic expect_frame(input int ok, input int err, input int bc, input logic pd);
        check(n_ok, ok);
        check(n_err, err);
        check(n_bc, bc);
        check(pend, pd);
        n_ok = 0;
        n_err = 0;
        n_bc = 0;
        rx_q.delete();
    endtask

    task automatic reply(input logic [7:0] fc, input logic exc, input logic [7:0] d);
        rsf_bytes_t e;
        int t;
        e = {own, fc | {exc, 7'h00}, d};
        e = with_crc(e);
        m.got.delete();
        r_start = 1'b1;
        r_exc = exc;
        @(negedge clk);
        r_start = 1'b0;
        check(tx_en, 1'b1);
        t_data = d;
        t_valid = 1'b1;
        t_last = 1'b1;
        for (t = 0; t < 50000 && tx_ready !== 1'b1; t++) @(negedge clk);
        check(t < 50000, 1'b1);
        @(negedge clk);
        t_valid = 1'b0;
        t_last = 1'b0;
        for (t = 0; t < 50000 && tx_en === 1'b1; t++) @(negedge clk);
        check(t < 50000, 1'b1);
        check(m.got.size(), e.size());
        foreach (e[i]) check(m.got[i], e[i]);
        check(m.bad, 0);
    endtask

    task automatic conclude();
        if (n_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    initial begin
        seed = $urandom(65);
        repeat (10) @(negedge clk);
        rst = 1'b0;
        check({addr_o, baud_o, fmt_o, txd, tx_en}, {own, rsf_pkg::BAUD_RESET, fm, 2'b10});
        cfg(8'h00, 3'h7, 2'h3);
        cfg(8'hF8, 3'h7, 2'h0);
        cfg(8'(1 + $urandom % 247), 3'h7, 2'h0);
        for (int r = 0; r < 8; r++) begin
            cfg(own, 3'(r), 2'(r % 3));
            fn = 8'(1 + $urandom % 255);
            f = {own, fn};
            if (r % 2 == 1) f.push_back(8'($urandom));
            f = with_crc(f);
            send(f, -1, -1, 1'b1);
            check(func_o, fn);
            check(rx_q.size(), f.size() - 1);
            foreach (rx_q[i]) check(rx_q[i], f[i + 1]);
            expect_frame(1, 0, 0, 1'b1);
            reply(fn, r % 2 == 1, 8'($urandom));
        end
        cfg(own, 3'h7, 2'h0);
        f = with_crc({own, fn});
        send(f, -1, -1, 1'b1);
        expect_frame(1, 0, 0, 1'b1);
        r_drop = 1'b1;
        @(negedge clk);
        r_drop = 1'b0;
        @(negedge clk);
        check({pend, tx_en}, 2'b00);
        send(with_crc({8'h00, fn}), -1, -1, 1'b1);
        expect_frame(1, 0, 1, 1'b0);
        r_start = 1'b1;
        @(negedge clk);
        r_start = 1'b0;
        repeat (20) @(negedge clk);
        check(tx_en, 1'b0);
        send(with_crc({(own == 8'hF7) ? 8'h01 : own + 8'h01, fn}), -1, -1, 1'b1);
        check(rx_q.size(), 0);
        expect_frame(0, 0, 0, 1'b0);
        f[f.size() - 1] ^= 8'h01;
        send(f, -1, -1, 1'b1);
        expect_frame(0, 1, 0, 1'b0);
        f = with_crc({own, fn});
        send(f, 1, -1, 1'b1);
        expect_frame(0, 1, 0, 1'b0);
        send(with_crc({own, fn, 8'hFF, 8'h12}), -1, 2, 1'b1);
        expect_frame(0, 1, 0, 1'b0);
        send(f, -1, -1, 1'b0);
        send(f, -1, -1, 1'b1);
        expect_frame(0, 1, 0, 1'b0);
        send(with_crc({own, 8'h00}), -1, -1, 1'b1);
        expect_frame(0, 1, 0, 1'b0);
        conclude();
    end

    initial begin
        repeat (90000) @(negedge clk);
        n_errors++;
        conclude();
    end
endmodule // testbench
